// file: verilog/icd_core.sv
// Functional notes
// - Clock control bit 7 picks standard or fast speed; disable keeps it.
// - Seven-bit divider field sets the hold-delay tick rate per speed mode.
// - Divider, own address bits and high address bits survive disable.
// - Writing the data register starts shifting a byte out as transmitter.
// - First received byte lands in data register after address phase.
// - Later bytes are received only after software reads the previous.
// - Seven-bit mode uses own address low bits 7..1 as slave address.
// - Seven-bit match ignores own address bit 0; either direction bit is acknowledged.
// - Own address value 01h never answers on the bus in seven-bit mode.
// - Ten-bit mode takes address bits 7..0 from own address low.
// - Ten-bit mode takes address bits 9..8 from high register bits 2..1.
// - Bus hold delays are timed from the frequency code.
// - High register resets to 40h; reserved bits read as zero.
// - Byte-done clears on status 1 read then data register access.
// - Serial clock is held low while byte-done is set.
// - Address match flag sets on own address or enabled general call.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module icd_core
    import icd_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Two-wire bus pins
    input wire icd_pins_s pin_i,
    output icd_pins_s pin_o,
    output icd_pins_s pin_oe,
    // Interrupt
    output logic irq
);
    // ==========================================
    // Registers
    logic [7:0] ctrl_reg, clk_reg, oal_reg, oah_reg, data_reg, aux_reg;
    logic [EV_W-1:0] irq_stat_reg, irq_mask_reg, ev_prev_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg, irq_reg;
    icd_state_e state_reg;
    logic [3:0] bit_cnt_reg, hold_cnt_reg;
    logic [7:0] shift_reg;
    logic [8:0] div_cnt_reg;
    logic tra_reg, btf_reg, address_matched_flag_reg, af_reg, stopf_reg, berr_reg;
    logic gcal_reg, busy_reg, sr1_seen_reg, nack_reg, addressed_reg;
    logic pend_low_reg, sda_oe_reg, scl_oe_reg;
    icd_pins_s sync1_reg, sync2_reg, prev_reg;

    // ==========================================
    // Bus decode
    logic [7:0] idx;
    logic setup_ph, acc_ph, wr_acc, rd_acc, mapped, pe;
    logic [7:0] sr1, sr2, rd_byte;
    logic [EV_W-1:0] ev_now;
    assign idx = paddr[9:2];
    assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
        (idx >= IDX_CTRL) && (idx <= IDX_AUX);
    assign setup_ph = psel && !penable;
    assign acc_ph = psel && penable && pready_reg;
    assign wr_acc = acc_ph && pwrite && mapped;
    assign rd_acc = acc_ph && !pwrite && mapped;
    assign pe = ctrl_reg[CR_PE];
    assign sr1 = {(btf_reg | address_matched_flag_reg | af_reg | stopf_reg | berr_reg),
        1'b0, tra_reg, busy_reg, btf_reg, address_matched_flag_reg, 2'b00};
    assign sr2 = {3'b000, af_reg, stopf_reg, 1'b0, berr_reg, gcal_reg};
    assign ev_now = {berr_reg, stopf_reg, af_reg, address_matched_flag_reg, btf_reg};

    // Read mux
    always_comb begin
        case (idx)
            IDX_CTRL: rd_byte = ctrl_reg;
            IDX_SR1: rd_byte = sr1;
            IDX_SR2: rd_byte = sr2;
            IDX_CLK: rd_byte = clk_reg;
            IDX_OAL: rd_byte = oal_reg;
            IDX_OAH: rd_byte = oah_reg;
            IDX_DATA: rd_byte = data_reg;
            IDX_IRQ_STAT: rd_byte = {3'b000, irq_stat_reg};
            IDX_IRQ_MASK: rd_byte = {3'b000, irq_mask_reg};
            IDX_AUX: rd_byte = aux_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    // Answer is latched in setup so the access phase ends in one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= 1'b1;
            if (setup_ph) begin
                prdata_reg <= (mapped && !pwrite) ? {24'h000000, rd_byte}
                                                  : 32'h0000_0000;
                pslverr_reg <= !mapped;
            end
        end
    end

    // ==========================================
    // Software registers; disable clears none of these
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 8'h00;
            clk_reg <= 8'h00;
            oal_reg <= 8'h00;
            oah_reg <= OAH_RESET;
            aux_reg <= 8'h00;
            irq_mask_reg <= '0;
        end else if (wr_acc) begin
            case (idx)
                IDX_CTRL: ctrl_reg <= pwdata[7:0] & CTRL_WMASK;
                IDX_CLK: clk_reg <= pwdata[7:0];
                IDX_OAL: oal_reg <= pwdata[7:0];
                IDX_OAH: begin
                    // Frequency only moves while disabled
                    oah_reg <= (pwdata[7:0] & OAH_ADDR_MASK) |
                        (pe ? (oah_reg & OAH_FR_MASK)
                            : (pwdata[7:0] & OAH_FR_MASK));
                end
                IDX_IRQ_MASK: irq_mask_reg <= pwdata[EV_W-1:0];
                IDX_AUX: aux_reg <= {7'h00, pwdata[AUX_TEN_BIT]};
                default: ;
            endcase
        end
    end

    // ==========================================
    // Interrupt: flag rise sets sticky status, write one clears, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
            ev_prev_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            ev_prev_reg <= ev_now;
            irq_stat_reg <= (irq_stat_reg &
                ~((wr_acc && idx == IDX_IRQ_STAT) ? pwdata[EV_W-1:0] : '0))
                | (ev_now & ~ev_prev_reg);
            irq_reg <= ctrl_reg[CR_ITE] && |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ==========================================
    // Pin synchronisers and edge detection on the second stage
    logic scl_rise, scl_fall, start_c, stop_c;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            prev_reg <= '1;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end
    assign scl_rise = sync2_reg.scl && !prev_reg.scl;
    assign scl_fall = !sync2_reg.scl && prev_reg.scl;
    assign start_c = sync2_reg.scl && prev_reg.scl &&
        prev_reg.sda && !sync2_reg.sda;
    assign stop_c = sync2_reg.scl && prev_reg.scl &&
        !prev_reg.sda && sync2_reg.sda;

    // ==========================================
    // Divider tick: fast mode counts the field, standard four times it
    logic [8:0] div_limit;
    logic tick;
    logic [3:0] hold_ticks;
    assign div_limit = clk_reg[7] ? {2'b00, clk_reg[6:0]}
                                  : {clk_reg[6:0], 2'b00};
    assign tick = (div_cnt_reg >= div_limit);
    assign hold_ticks = (oah_reg[7:6] == FR_BELOW_6MHZ) ? HOLD_TICKS_SLOW
                                                       : HOLD_TICKS_FAST;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 9'h000;
        end else begin
            div_cnt_reg <= tick ? 9'h000 : div_cnt_reg + 9'h001;
        end
    end

    // ==========================================
    // Address comparison
    logic match7, gcall, hdr_match, match_any;
    assign match7 = (shift_reg[7:1] == oal_reg[7:1]) &&
        (oal_reg != OAL_NEVER);
    assign gcall = (shift_reg == 8'h00) && ctrl_reg[CR_GENERAL_CALL_ENABLE];
    assign hdr_match = (shift_reg[7:3] == HDR_TEN_BIT) &&
        (shift_reg[2:1] == oah_reg[2:1]);
    assign match_any = gcall ||
        (aux_reg[AUX_TEN_BIT] ? hdr_match : match7);

    // Byte-done clear needs status 1 read, then the right data access
    logic dr_wr, dr_rd, btf_clr;
    assign dr_wr = wr_acc && idx == IDX_DATA;
    assign dr_rd = rd_acc && idx == IDX_DATA;
    assign btf_clr = sr1_seen_reg && (tra_reg ? dr_wr : dr_rd);

    // ==========================================
    // Slave protocol engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            data_reg <= 8'h00;
            tra_reg <= 1'b0;
            btf_reg <= 1'b0;
            address_matched_flag_reg <= 1'b0;
            af_reg <= 1'b0;
            stopf_reg <= 1'b0;
            berr_reg <= 1'b0;
            gcal_reg <= 1'b0;
            busy_reg <= 1'b0;
            sr1_seen_reg <= 1'b0;
            nack_reg <= 1'b0;
            addressed_reg <= 1'b0;
            pend_low_reg <= 1'b0;
            hold_cnt_reg <= 4'h0;
        end else if (!pe) begin
            // Disable drops flags; busy is simply not tracked
            state_reg <= ST_IDLE;
            tra_reg <= 1'b0;
            btf_reg <= 1'b0;
            address_matched_flag_reg <= 1'b0;
            af_reg <= 1'b0;
            stopf_reg <= 1'b0;
            berr_reg <= 1'b0;
            gcal_reg <= 1'b0;
            sr1_seen_reg <= 1'b0;
            addressed_reg <= 1'b0;
            pend_low_reg <= 1'b0;
            hold_cnt_reg <= 4'h0;
            if (dr_wr) begin
                data_reg <= pwdata[7:0];
            end
        end else begin
            if (hold_cnt_reg != 4'h0 && tick) begin
                hold_cnt_reg <= hold_cnt_reg - 4'h1;
            end
            // Status 1 read arms byte-done clear and drops address match
            if (rd_acc && idx == IDX_SR1) begin
                sr1_seen_reg <= btf_reg;
                address_matched_flag_reg <= 1'b0;
            end
            if (rd_acc && idx == IDX_SR2) begin
                af_reg <= 1'b0;
                stopf_reg <= 1'b0;
                berr_reg <= 1'b0;
            end
            if (btf_clr) begin
                btf_reg <= 1'b0;
                sr1_seen_reg <= 1'b0;
            end
            if (dr_wr) begin
                data_reg <= pwdata[7:0];
                if (tra_reg && state_reg == ST_XFER) begin
                    // Load and present the first bit under stretch
                    shift_reg <= pwdata[7:0];
                    pend_low_reg <= !pwdata[7];
                    hold_cnt_reg <= hold_ticks;
                end
            end
            if (start_c || stop_c) begin
                busy_reg <= start_c;
                // One high clock before it is the normal stop or restart
                if (bit_cnt_reg > 4'h1 && bit_cnt_reg < BITS_PER_BYTE) begin
                    berr_reg <= 1'b1;
                end
                if (stop_c && addressed_reg) begin
                    stopf_reg <= 1'b1;
                end
                if (stop_c) begin
                    gcal_reg <= 1'b0;
                    addressed_reg <= 1'b0;
                end
                state_reg <= start_c ? ST_ADDR : ST_IDLE;
                bit_cnt_reg <= 4'h0;
                pend_low_reg <= 1'b0;
                hold_cnt_reg <= 4'h0;
            end else if (state_reg != ST_IDLE && state_reg != ST_SKIP) begin
                if (scl_rise) begin
                    if (bit_cnt_reg < BITS_PER_BYTE) begin
                        shift_reg <= {shift_reg[6:0], sync2_reg.sda};
                    end else begin
                        nack_reg <= sync2_reg.sda;
                    end
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end else if (scl_fall) begin
                    hold_cnt_reg <= hold_ticks;
                    if (bit_cnt_reg < BITS_PER_BYTE) begin
                        pend_low_reg <= tra_reg && state_reg == ST_XFER &&
                            !shift_reg[7];
                    end else if (bit_cnt_reg == BITS_PER_BYTE) begin
                        // Acknowledge slot
                        case (state_reg)
                            ST_ADDR: begin
                                pend_low_reg <= match_any;
                                if (!match_any) begin
                                    state_reg <= ST_SKIP;
                                end
                            end
                            ST_ADDR2: begin
                                // Low eight address bits
                                pend_low_reg <= (shift_reg == oal_reg);
                                if (shift_reg != oal_reg) begin
                                    state_reg <= ST_SKIP;
                                end
                            end
                            default: begin
                                if (!tra_reg) begin
                                    data_reg <= shift_reg;
                                    pend_low_reg <= ctrl_reg[CR_ACK];
                                end else begin
                                    pend_low_reg <= 1'b0;
                                end
                            end
                        endcase
                    end else if (bit_cnt_reg == ACK_BIT) begin
                        bit_cnt_reg <= 4'h0;
                        pend_low_reg <= 1'b0;
                        case (state_reg)
                            ST_ADDR: begin
                                if (aux_reg[AUX_TEN_BIT] && !gcall &&
                                    !shift_reg[0]) begin
                                    state_reg <= ST_ADDR2;
                                end else begin
                                    address_matched_flag_reg <= 1'b1;
                                    addressed_reg <= 1'b1;
                                    gcal_reg <= gcall;
                                    tra_reg <= shift_reg[0];
                                    btf_reg <= shift_reg[0];
                                    state_reg <= ST_XFER;
                                end
                            end
                            ST_ADDR2: begin
                                address_matched_flag_reg <= 1'b1;
                                addressed_reg <= 1'b1;
                                tra_reg <= 1'b0;
                                state_reg <= ST_XFER;
                            end
                            default: begin
                                if (tra_reg && nack_reg) begin
                                    af_reg <= 1'b1;
                                    state_reg <= ST_SKIP;
                                end else if (!tra_reg && !ctrl_reg[CR_ACK]) begin
                                    state_reg <= ST_SKIP;
                                end else begin
                                    // Stretch until software services it
                                    btf_reg <= 1'b1;
                                end
                            end
                        endcase
                    end
                end
            end
        end
    end

    // ==========================================
    // Open-drain drivers; data waits out the hold delay except on disable, start or stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
        end else begin
            if (!pe) begin
                sda_oe_reg <= 1'b0;
            end else if (hold_cnt_reg == 4'h0) begin
                sda_oe_reg <= pend_low_reg;
            end
            scl_oe_reg <= pe && (btf_reg || address_matched_flag_reg);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign pin_o = '0;
    assign pin_oe = '{scl: scl_oe_reg, sda: sda_oe_reg};
endmodule
`default_nettype wire

// file: verilog/icd_pkg.sv
package icd_pkg;
    // ==========================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h18;
    localparam logic [7:0] IDX_SR1 = 8'h19;
    localparam logic [7:0] IDX_SR2 = 8'h1A;
    localparam logic [7:0] IDX_CLK = 8'h1B;
    localparam logic [7:0] IDX_OAL = 8'h1C;
    localparam logic [7:0] IDX_OAH = 8'h1D;
    localparam logic [7:0] IDX_DATA = 8'h1E;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h1F;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h20;
    localparam logic [7:0] IDX_AUX = 8'h21;
    // ==========================================
    // Control register fields
    localparam int CR_PE = 5;
    localparam int CR_GENERAL_CALL_ENABLE = 4;
    localparam int CR_ACK = 2;
    localparam int CR_ITE = 0;
    localparam logic [7:0] CTRL_WMASK = 8'h3F;
    // Own address high / frequency register
    localparam logic [7:0] OAH_RESET = 8'h40;
    localparam logic [7:0] OAH_ADDR_MASK = 8'h06;
    localparam logic [7:0] OAH_FR_MASK = 8'hC0;
    localparam logic [7:0] OAL_NEVER = 8'h01;
    localparam logic [4:0] HDR_TEN_BIT = 5'h1E;
    localparam int AUX_TEN_BIT = 0;
    // Interrupt event bit positions
    localparam int EV_BTF = 0;
    localparam int EV_ADDRESS_MATCHED_FLAG = 1;
    localparam int EV_AF = 2;
    localparam int EV_STOPF = 3;
    localparam int EV_BERR = 4;
    localparam int EV_W = 5;
    // ==========================================
    // Timing: bus hold delays in divider ticks, per frequency code
    localparam int CLK_MHZ = 125;
    localparam logic [1:0] FR_BELOW_6MHZ = 2'h0;
    localparam logic [3:0] HOLD_TICKS_SLOW = 4'h1;
    localparam logic [3:0] HOLD_TICKS_FAST = 4'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_BIT = 4'h9;
    // ==========================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR2 = 3'b010,
        ST_XFER = 3'b011,
        ST_SKIP = 3'b100
    } icd_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } icd_pins_s;
endpackage

// file: bench/icd_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module icd_assertions
    import icd_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Bus pins and interrupt
    input wire icd_pins_s pin_i,
    input wire icd_pins_s pin_oe,
    input wire logic irq
);
    // ==========================================
    // Access decode
    localparam logic [11:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [11:0] A_OAH = {2'h0, IDX_OAH, 2'h0};
    localparam logic [11:0] A_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
    logic acc;
    logic wr;
    logic in_map;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign in_map = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0
        && paddr[9:2] >= IDX_CTRL && paddr[9:2] <= IDX_AUX;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ==========================================
    // Register bus
    a_ready_access: assert property (acc && $past(presetn) |-> pready)
        else $error("pready low in access phase");
    a_upper_zero: assert property (acc |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_err_unmapped: assert property (acc && !in_map |-> pslverr)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (acc && in_map |-> !pslverr)
        else $error("error on mapped access");
    a_oah_reserved: assert property (
        psel && !penable && !pwrite && paddr == A_OAH
        |=> prdata[5:3] == 3'h0 && prdata[0] == 1'b0)
        else $error("reserved address bits read nonzero");
    // ==========================================
    // Serial lines and interrupt
    a_disable_frees: assert property (
        wr && paddr == A_CTRL && !pwdata[CR_PE] |-> ##[1:3] pin_oe == 2'h0)
        else $error("lines still held after disable");
    a_sda_scl_low: assert property ($changed(pin_oe.sda) |-> !pin_i.scl)
        else $error("data line moved while clock high");
    a_hold_start_low: assert property ($rose(pin_oe.scl) |-> !pin_i.scl)
        else $error("clock hold began while clock high");
    a_irq_masked: assert property (
        wr && paddr == A_MASK && pwdata[7:0] == 8'h00 |-> ##2 !irq)
        else $error("interrupt high with all sources masked");
endmodule

bind icd_core icd_assertions icd_assertions_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_i(pin_i), .pin_oe(pin_oe), .irq(irq));
`default_nettype wire

// file: bench/icd_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module icd_bus_model (
    // Clock
    input wire logic pclk,
    // Wire levels
    input wire logic scl_i,
    input wire logic sda_i,
    // Open-drain pulls, high pulls low
    output var logic scl_oe,
    output var logic sda_oe
);
    // ==========================================
    // Bus master, slow enough for the hold delays of the divider settings used here
    localparam int HALF = 20;
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    task automatic half_bit();
        repeat (HALF) @(posedge pclk);
    endtask
    // Release clock; a stretching slave keeps it low
    task automatic scl_up();
        int n;
        n = 0;
        scl_oe <= 1'b0;
        @(posedge pclk);
        while (!scl_i && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        half_bit();
    endtask
    task automatic start();
        sda_oe <= 1'b1;
        half_bit();
        scl_oe <= 1'b1;
        half_bit();
    endtask
    // Eight data bits then acknowledge; a one releases the line
    task automatic bits9(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_oe <= !d[i];
            half_bit();
            scl_up();
            r[i] = sda_i;
            scl_oe <= 1'b1;
            half_bit();
        end
    endtask
    task automatic stop();
        sda_oe <= 1'b1;
        half_bit();
        scl_up();
        sda_oe <= 1'b0;
        half_bit();
    endtask
endmodule
`default_nettype wire

// file: bench/icd_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module icd_core_tb
    import icd_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic m_scl, m_sda, err;
    logic [8:0] r;
    icd_pins_s pin_i, pin_oe;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;

    icd_core icd_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
        .pin_o(), .pin_oe(pin_oe), .irq(irq));
    icd_bus_model icd_bus_model_i (.pclk(pclk), .scl_i(pin_i.scl),
        .sda_i(pin_i.sda), .scl_oe(m_scl), .sda_oe(m_sda));

    // Open-drain wires with pull-ups
    assign pin_i = {~(m_scl | pin_oe.scl), ~(m_sda | pin_oe.sda)};

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Cut a hang well past the expected run length
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc > 30000) begin
            error_cnt++;
            final_report();
        end
    end

    // ==========================================
    // Helpers
    task automatic final_report();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; idle edge first so strobes never double up
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {2'h0, idx, 2'h0}, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] m,
                      input logic [7:0] e);
        apb(1'b0, {2'h0, idx, 2'h0}, 32'h0);
        chk(v & {24'h0, m}, {24'h0, e});
    endtask
    task automatic pause();
        repeat (3) @(posedge pclk);
    endtask

    // ==========================================
    // Sequence
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(IDX_CTRL + 8'(i), 8'hFF, (i == 5) ? 8'h40 : 8'h00);
        end
        apb(1'b0, {2'h0, IDX_CTRL, 2'h1}, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(v, 32'h0);
        apb(1'b0, {2'h0, 8'h30, 2'h0}, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Frequency field locked while enabled, setup kept on disable
        wr(IDX_OAH, 8'hFF);
        rd(IDX_OAH, 8'hFF, 8'hC6);
        wr(IDX_CLK, 8'h85);
        wr(IDX_OAL, 8'hA5);
        wr(IDX_CTRL, 8'h25);
        wr(IDX_OAH, 8'h04);
        rd(IDX_OAH, 8'hFF, 8'hC4);
        wr(IDX_CTRL, 8'h00);
        rd(IDX_CLK, 8'hFF, 8'h85);
        rd(IDX_OAL, 8'hFF, 8'hA5);
        rd(IDX_OAH, 8'hFF, 8'hC4);
        wr(IDX_OAH, 8'h40);
        // Write to us: address, hold, interrupt, then one data byte
        wr(IDX_IRQ_MASK, 8'h1F);
        wr(IDX_CTRL, 8'h25);
        icd_bus_model_i.start();
        icd_bus_model_i.bits9({8'hA4, 1'b1}, r);
        chk(32'(r[0]), 32'h0);
        chk(32'(pin_oe.scl), 32'h1);
        chk(32'(irq), 32'h1);
        wr(IDX_IRQ_MASK, 8'h00);
        pause();
        chk(32'(irq), 32'h0);
        wr(IDX_IRQ_MASK, 8'h1F);
        wr(IDX_IRQ_STAT, 8'h1F);
        pause();
        chk(32'(irq), 32'h0);
        rd(IDX_SR1, 8'h04, 8'h04);
        pause();
        chk(32'(pin_oe.scl), 32'h0);
        icd_bus_model_i.bits9({8'h3C, 1'b1}, r);
        chk(32'(r[0]), 32'h0);
        rd(IDX_DATA, 8'hFF, 8'h3C);
        pause();
        chk(32'(pin_oe.scl), 32'h1);
        rd(IDX_SR1, 8'h28, 8'h08);
        rd(IDX_DATA, 8'hFF, 8'h3C);
        pause();
        chk(32'(pin_oe.scl), 32'h0);
        icd_bus_model_i.stop();
        // Read from us: software byte goes out, master refuses it
        icd_bus_model_i.start();
        icd_bus_model_i.bits9({8'hA5, 1'b1}, r);
        rd(IDX_SR1, 8'h2C, 8'h2C);
        wr(IDX_DATA, 8'hC3);
        icd_bus_model_i.bits9(9'h1FF, r);
        chk(32'(r[8:1]), 32'hC3);
        rd(IDX_SR2, 8'h10, 8'h10);
        icd_bus_model_i.stop();
        // Seven-bit address 01h is never answered
        wr(IDX_OAL, 8'h01);
        icd_bus_model_i.start();
        icd_bus_model_i.bits9({8'h01, 1'b1}, r);
        chk(32'(r[0]), 32'h1);
        icd_bus_model_i.stop();
        // Ten-bit: header carries high bits, second byte low bits
        wr(IDX_AUX, 8'h01);
        wr(IDX_OAL, 8'h5A);
        wr(IDX_OAH, 8'h44);
        icd_bus_model_i.start();
        icd_bus_model_i.bits9({8'hF4, 1'b1}, r);
        chk(32'(r[0]), 32'h0);
        icd_bus_model_i.bits9({8'h5A, 1'b1}, r);
        chk(32'(r[0]), 32'h0);
        rd(IDX_SR1, 8'h04, 8'h04);
        icd_bus_model_i.stop();
        // General call in standard speed with the short hold code
        wr(IDX_CTRL, 8'h00);
        wr(IDX_OAH, 8'h04);
        wr(IDX_CLK, 8'h01);
        wr(IDX_CTRL, 8'h35);
        icd_bus_model_i.start();
        icd_bus_model_i.bits9({8'h00, 1'b1}, r);
        chk(32'(r[0]), 32'h0);
        rd(IDX_SR2, 8'h03, 8'h01);
        rd(IDX_SR1, 8'h04, 8'h04);
        icd_bus_model_i.stop();
        wr(IDX_CTRL, 8'h00);
        pause();
        final_report();
    end
endmodule
`default_nettype wire
